//--- inc/sdrb_params.svh
/*
  Constants of the read-burst block: register offsets, field positions, reset values, fixed counts.
  Assumes inclusion by bare name from the package and the design file.
*/
// Notes on behaviour
// - bursts: fixed eight, fixed four, per-command choice
// - per-command mode: chop bit low gives four
// - auto-precharge bit low leaves bank open
// - auto-precharge bit high closes bank afterwards
// - eight beats for field 00, or 01 with bit high
// - release outputs at latency plus four or two
// - reads served only while the delay loop locked
// - one data beat per strobe edge
// - first beat after additive plus cas latency
// - postamble always half a clock
// - mode four bit eleven picks preamble length
`ifndef SDRB_PARAMS_SVH
`define SDRB_PARAMS_SVH
`define SDRB_OFS_MR0       4'h0
`define SDRB_OFS_MR4       4'h4
`define SDRB_OFS_LAT       4'h8
`define SDRB_OFS_STAT      4'hC
`define SDRB_MR0_BL_LSB    0
`define SDRB_MR4_RPRE_BIT  11
`define SDRB_LAT_CL_LSB    0
`define SDRB_LAT_AL_LSB    8
`define SDRB_STAT_DLL_BIT  8
`define SDRB_STAT_BUSY_BIT 9
`define SDRB_STAT_DROP_BIT 10
`define SDRB_MR0_RESET     32'h0000_0000
`define SDRB_MR4_RESET     32'h0000_0000
`define SDRB_CL_RESET      5'h0B
`define SDRB_AL_RESET      5'h00
`define SDRB_BEATS_LONG    4'h8
`define SDRB_BEATS_CHOP    4'h4
`define SDRB_CLKS_LONG     6'h04
`define SDRB_CLKS_CHOP     6'h02
`define SDRB_PRE_SHORT     6'h01
`define SDRB_PRE_LONG      6'h02
`endif

//--- inc/sdrb_pkg.sv
/*
  Types of the read-burst block.
  Assumes sdrb_params.svh is on the include path.
*/
package sdrb_pkg;
  `include "sdrb_params.svh"

  typedef enum logic [1:0] {
    SDRB_BL_FIXED8 = 2'h0,
    SDRB_BL_OTF    = 2'h1,
    SDRB_BL_FIXED4 = 2'h2,
    SDRB_BL_RSVD   = 2'h3
  } sdrb_bl_e;

  typedef enum logic [2:0] {
    SDRB_IDLE  = 3'h0,
    SDRB_WAIT  = 3'h1,
    SDRB_PRE   = 3'h3,
    SDRB_BURST = 3'h2,
    SDRB_POST  = 3'h6
  } sdrb_state_e;

  typedef struct packed {
    logic       readCmd;
    logic       actCmd;
    logic       autoPrechargeAddrBit;
    logic       burstChopAddrBit;
    logic [1:0] bank;
  } sdrb_cmd_s;
endpackage

//--- core/sdrb_read_burst.sv
/*
  Device-side read-burst engine: command capture on the memory clock, latency count, preamble,
  strobe and data launch on both clock edges, postamble and output release, bank open tracking.
  Assumes memClk and all pin inputs are asynchronous to clk_sys and much slower (8x or more);
  software uses the plain register port; rdData is on the clk_sys domain and holds burst data.
*/
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "sdrb_params.svh"

module sdrb_read_burst
  import sdrb_pkg::*;
#(
  parameter int DQ_W    = 8,
  parameter int BANKS   = 4
)(
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic [3:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  input  wire logic                 memClk,
  input  wire sdrb_cmd_s            cmdPin,
  input  wire logic                 dllLocked,
  input  wire logic [8*DQ_W-1:0]    rdData,
  output logic                      dqsT,
  output logic                      dqsC,
  output logic                      dqsOe,
  output logic      [DQ_W-1:0]      dqOut,
  output logic                      dqOe,
  output logic      [BANKS-1:0]     bankOpen
);

  // the bank field is two bits wide, so exactly four banks are served
  if (DQ_W < 1 || DQ_W > 32 || BANKS != 4) begin : g_bad_params
    $error("sdrb_read_burst: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SW = $bits(sdrb_cmd_s) + 2;
  logic [SW-1:0] pinMeta_reg;
  logic [SW-1:0] pinSync_reg;
  logic          clkPrev_reg;
  sdrb_cmd_s     cmdS;
  logic          dllS;
  logic          ckS;
  logic          ckRise;
  logic          ckFall;

  // clock and command share one flop pair, so both are seen on the same edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      clkPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {memClk, dllLocked, cmdPin};
      pinSync_reg <= pinMeta_reg;
      clkPrev_reg <= ckS;
    end
  end

  assign ckS    = pinSync_reg[SW-1];
  assign dllS   = pinSync_reg[SW-2];
  assign cmdS   = pinSync_reg[SW-3:0];
  // edges are found after the second flop only; the first may still be settling
  assign ckRise = ckS & ~clkPrev_reg;
  assign ckFall = ~ckS & clkPrev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  sdrb_bl_e    blMode_reg;
  logic        longPre_reg;
  logic [4:0]  casLat_reg;
  logic [4:0]  addLat_reg;
  logic        dropped_reg;
  sdrb_state_e state_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      blMode_reg  <= sdrb_bl_e'(`SDRB_MR0_RESET);
      longPre_reg <= 1'b0;
      casLat_reg  <= `SDRB_CL_RESET;
      addLat_reg  <= `SDRB_AL_RESET;
    end else if (regWr) begin
      case (regAddr)
        `SDRB_OFS_MR0: blMode_reg <= sdrb_bl_e'(regWrData[`SDRB_MR0_BL_LSB +: 2]);
        `SDRB_OFS_MR4: longPre_reg <= regWrData[`SDRB_MR4_RPRE_BIT];
        `SDRB_OFS_LAT: begin
          casLat_reg <= regWrData[`SDRB_LAT_CL_LSB +: 5];
          addLat_reg <= regWrData[`SDRB_LAT_AL_LSB +: 5];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        `SDRB_OFS_MR0:  regRdData <= {30'h0, blMode_reg};
        `SDRB_OFS_MR4:  regRdData <= 32'(longPre_reg) << `SDRB_MR4_RPRE_BIT;
        `SDRB_OFS_LAT:  regRdData <= {19'h0, addLat_reg, 3'h0, casLat_reg};
        `SDRB_OFS_STAT: regRdData <= {21'h0, dropped_reg, state_reg != SDRB_IDLE, dllS,
                                      4'h0, 4'(bankOpen)};
        default:        regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic       readTake;
  logic       chopNow;
  logic [5:0] readLat;
  logic [5:0] preClks;
  logic [5:0] preStart;

  // ignore reads without a locked loop
  assign readTake = ckRise & cmdS.readCmd & dllS;
  assign readLat  = 6'(addLat_reg) + 6'(casLat_reg);
  assign preClks  = longPre_reg ? `SDRB_PRE_LONG : `SDRB_PRE_SHORT;
  assign preStart = (readLat > preClks) ? 6'(readLat - preClks) : 6'h00;

  always_comb begin
    unique case (blMode_reg)
      SDRB_BL_FIXED4: chopNow = 1'b1;
      // chop bit low chops, high gives eight
      SDRB_BL_OTF:    chopNow = ~cmdS.burstChopAddrBit;
      default:        chopNow = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer

  logic [5:0]      clkCnt_reg;
  logic [5:0]      target_reg;
  logic [5:0]      preAt_reg;
  logic [3:0]      beat_reg;
  logic [3:0]      lastBeat_reg;
  logic            chop_reg;
  logic            ap_reg;
  logic [1:0]      bank_reg;
  logic [DQ_W-1:0] beatMem_reg [8];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chop_reg     <= 1'b0;
      ap_reg       <= 1'b0;
      bank_reg     <= 2'h0;
      lastBeat_reg <= 4'h0;
    end else if (state_reg == SDRB_IDLE && readTake) begin
      chop_reg     <= chopNow;
      ap_reg       <= cmdS.autoPrechargeAddrBit;
      bank_reg     <= cmdS.bank;
      lastBeat_reg <= (chopNow ? `SDRB_BEATS_CHOP : `SDRB_BEATS_LONG) - 4'h1;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_beat
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        beatMem_reg[i] <= '0;
      end else if (state_reg == SDRB_IDLE && readTake) begin
        beatMem_reg[i] <= rdData[i*DQ_W +: DQ_W];
      end
    end
  end

  // one burst in flight; a read arriving while busy is dropped and flagged
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dropped_reg <= 1'b0;
    end else if (ckRise && cmdS.readCmd && (state_reg != SDRB_IDLE || !dllS)) begin
      dropped_reg <= 1'b1;
    end else if (regRd && regAddr == `SDRB_OFS_STAT) begin
      dropped_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= SDRB_IDLE;
      clkCnt_reg <= 6'h00;
      target_reg <= 6'h00;
      preAt_reg  <= 6'h00;
      beat_reg   <= 4'h0;
      dqsT       <= 1'b0;
      dqsC       <= 1'b1;
      dqsOe      <= 1'b0;
      dqOe       <= 1'b0;
      dqOut      <= '0;
    end else begin
      unique case (state_reg)
        SDRB_IDLE: begin
          if (readTake) begin
            clkCnt_reg <= 6'h00;
            target_reg <= readLat;
            // setup is captured per read; a register write mid-burst waits for the next one
            preAt_reg  <= preStart;
            beat_reg   <= 4'h0;
            if (preStart == 6'h00) begin
              state_reg <= SDRB_PRE;
              dqsOe     <= 1'b1;
            end else begin
              state_reg <= SDRB_WAIT;
            end
          end
        end
        SDRB_WAIT: begin
          if (ckRise) begin
            clkCnt_reg <= clkCnt_reg + 6'h01;
            if (clkCnt_reg + 6'h01 == preAt_reg) begin
              state_reg <= SDRB_PRE;
              dqsOe     <= 1'b1;
              dqsT      <= 1'b0;
              dqsC      <= 1'b1;
            end
          end
        end
        SDRB_PRE: begin
          if (ckRise) begin
            clkCnt_reg <= clkCnt_reg + 6'h01;
            if (clkCnt_reg + 6'h01 >= target_reg) begin
              state_reg <= SDRB_BURST;
              dqsT      <= 1'b1;
              dqsC      <= 1'b0;
              dqOe      <= 1'b1;
              dqOut     <= beatMem_reg[0];
            end
          end
        end
        SDRB_BURST: begin
          if (ckFall) begin
            dqsT <= 1'b0;
            dqsC <= 1'b1;
            if (beat_reg + 4'h1 <= lastBeat_reg) begin
              beat_reg <= beat_reg + 4'h1;
              dqOut    <= beatMem_reg[3'(beat_reg + 4'h1)];
            end
            if (beat_reg + 4'h1 >= lastBeat_reg) begin
              state_reg <= SDRB_POST;
            end
          end else if (ckRise) begin
            beat_reg <= beat_reg + 4'h1;
            dqsT     <= 1'b1;
            dqsC     <= 1'b0;
            dqOut    <= beatMem_reg[3'(beat_reg + 4'h1)];
          end
        end
        SDRB_POST: begin
          if (ckRise) begin
            // release at latency plus four or two
            state_reg <= SDRB_IDLE;
            dqsOe     <= 1'b0;
            dqOe      <= 1'b0;
            dqsT      <= 1'b0;
            dqsC      <= 1'b1;
          end
        end
        default: state_reg <= SDRB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank open tracking

  logic burstEnd;
  assign burstEnd = (state_reg == SDRB_POST) && ckRise;

  // an activate in the release cycle wins over the auto-precharge close
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        bankOpen[b] <= 1'b0;
      end else if (ckRise && cmdS.actCmd && cmdS.bank == 2'(b)) begin
        bankOpen[b] <= 1'b1;
      end else if (burstEnd && ap_reg && bank_reg == 2'(b)) begin
        bankOpen[b] <= 1'b0;
      end
      // plain read leaves bank as it was
    end
  end

endmodule

//--- tb/sdrb_read_burst_chk.sv
/*
  Port checker of the read-burst block: strobe shape, preamble, release, bank close.
  Assumes bind onto sdrb_read_burst and a link clock of 8 clk_sys periods.
*/
`timescale 1ns/1ns
module sdrb_read_burst_chk
  import sdrb_pkg::*;
#(
  parameter int DQ_W  = 8,
  parameter int BANKS = 4
)(
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             dqsT,
  input wire logic             dqsC,
  input wire logic             dqsOe,
  input wire logic             dqOe,
  input wire logic [BANKS-1:0] bankOpen
);
  logic [7:0] oeCnt_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // driven span in clk_sys cycles; 8 per link clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      oeCnt_reg <= 8'h00;
    else
      oeCnt_reg <= dqOe ? oeCnt_reg + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////
  data_strobe_a: assert property (dqOe |-> dqsOe)
    else $error("data without strobe");
  strobe_legs_a: assert property (dqsOe |-> dqsC != dqsT)
    else $error("strobe legs equal");
  strobe_high_a: assert property ($rose(dqsT) |-> dqOe ##0 dqsT[*4] ##1 !dqsT)
    else $error("strobe high not half clock");
  preamble_a: assert property ($rose(dqsOe) |-> !dqsT[*8] ##1 (dqsT or (!dqsT[*8] ##1 dqsT)))
    else $error("bad preamble");
  release_pair_a: assert property ($fell(dqOe) |-> $fell(dqsOe))
    else $error("data and strobe released apart");
  post_low_a: assert property ($fell(dqsOe) |-> $past(dqsT, 5) && !$past(dqsT, 4) && !$past(dqsT, 1))
    else $error("postamble not half clock");
  burst_len_a: assert property ($fell(dqOe) |-> oeCnt_reg == 8'h20 || oeCnt_reg == 8'h10)
    else $error("burst span wrong");
  bank_close_a: assert property (|($past(bankOpen) & ~bankOpen) |-> $fell(dqsOe))
    else $error("bank closed outside release");
  cover property ($fell(dqOe) && oeCnt_reg == 8'h20);
  cover property ($fell(dqOe) && oeCnt_reg == 8'h10);
  cover property (|($past(bankOpen) & ~bankOpen));
  cover property ($rose(dqsOe) ##16 $rose(dqsT));
endmodule

bind sdrb_read_burst sdrb_read_burst_chk #(.DQ_W(DQ_W), .BANKS(BANKS)) chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .dqsT(dqsT), .dqsC(dqsC), .dqsOe(dqsOe), .dqOe(dqOe), .bankOpen(bankOpen));

//--- tb/sdrb_ctrl_model.sv
/*
  Memory controller model: free-running link clock and activate/read commands.
  Assumes the bench reads edges and t0 to time bursts.
*/
`timescale 1ns/1ns
module sdrb_ctrl_model
  import sdrb_pkg::*;
(
  output logic      memClk,
  output sdrb_cmd_s cmdPin
);
  int edges = 0;
  int t0    = 0;
  initial begin
    memClk = 1'h0;
    cmdPin = '0;
    #37;
    forever #400 memClk = ~memClk;
  end
  always @(posedge memClk) edges++;
  ////////////////////////////////////////
  // chop bit sent with each read
  task cmd(input logic rd, ap, bc, input logic [1:0] bk);
    @(negedge memClk);
    cmdPin <= '{rd, !rd, ap, bc, bk};
    t0 = edges + 1;
    @(negedge memClk);
    // released bus shows inverted junk, not the old command
    cmdPin <= '{1'h0, 1'h0, !ap, !bc, ~bk};
  endtask
endmodule

//--- tb/tb.sv
/*
  Bench of the read-burst block: registers, all burst modes, latency, release, banks, unlocked loop.
  Assumes sdrb_ctrl_model as far side and the bound port checker.
*/
`timescale 1ns/1ns
`include "sdrb_params.svh"
module tb;
  logic                clk_sys, sys_rst, regWr, regRd, dllLocked, memClk, dqsT, dqsC, dqsOe, dqOe;
  logic                pOe, pT, pSo;
  logic [3:0]          regAddr, bankOpen, bo;
  logic [31:0]         regWrData, regRdData;
  logic [63:0]         rdData;
  logic [7:0]          dqOut;
  logic [7:0]          q[$];
  sdrb_pkg::sdrb_cmd_s cmdPin;
  int                  miscompares = 0, checks = 0, eS, eR, eF, n;
  sdrb_read_burst dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memClk(memClk), .cmdPin(cmdPin),
    .dllLocked(dllLocked), .rdData(rdData), .dqsT(dqsT), .dqsC(dqsC), .dqsOe(dqsOe), .dqOut(dqOut),
    .dqOe(dqOe), .bankOpen(bankOpen));
  sdrb_ctrl_model ctrl_u (.memClk(memClk), .cmdPin(cmdPin));
  ////////////////////////////////////////
  task chk(input logic [63:0] s, e, input string nm);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    @(negedge clk_sys);
    chk(regRdData, e, "regRdData");
  endtask
  // beat capture: one beat per strobe edge while data is driven
  always @(posedge clk_sys) begin
    if (dqOe && (!pOe || dqsT !== pT)) q.push_back(dqOut);
    if (dqsOe && !pSo) eS = ctrl_u.edges;
    if (dqOe && !pOe) eR = ctrl_u.edges;
    if (!dqOe && pOe) eF = ctrl_u.edges;
    pOe = dqOe;
    pT = dqsT;
    pSo = dqsOe;
  end
  task burst(input logic [1:0] f, input logic bc, pre, ap, input logic [1:0] bk);
    int cl, al, nb;
    cl = $urandom_range(11, 3);
    al = $urandom_range(3, 0);
    nb = (f == 2'h2 || (f == 2'h1 && !bc)) ? 4 : 8;
    @(posedge clk_sys);
    rdData <= {$urandom, $urandom};
    wr(`SDRB_OFS_LAT, (al << 8) | cl);
    wr(`SDRB_OFS_MR0, {30'h0, f});
    wr(`SDRB_OFS_MR4, {20'h0, pre, 11'h0});
    ctrl_u.cmd(1'h0, ap, bc, bk);
    bo[bk] = 1'h1;
    q = {};
    eF = 0;
    ctrl_u.cmd(1'h1, ap, bc, bk);
    for (int k = 0; k < 400 && eF == 0; k++) @(posedge clk_sys);
    chk(q.size(), nb, "beats");
    for (int k = 0; k < nb; k++) chk(q[k], rdData[k*8 +: 8], "beat");
    chk(eR - ctrl_u.t0, al + cl, "latency");
    chk(eS - ctrl_u.t0, al + cl - (pre ? 2 : 1), "preamble");
    chk(eF - ctrl_u.t0, al + cl + nb / 2, "release");
    if (ap) bo[bk] = 1'h0;
    chk(bankOpen, bo, "bankOpen");
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  initial begin
    {sys_rst, regWr, regRd, regAddr, regWrData, dllLocked, rdData} = '0;
    sys_rst = 1'h1;
    dllLocked = 1'h1;
    {bo, pOe, pT, pSo} = '0;
    n = $urandom(26);
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rd(`SDRB_OFS_LAT, {19'h0, `SDRB_AL_RESET, 3'h0, `SDRB_CL_RESET});
    rd(`SDRB_OFS_MR0, `SDRB_MR0_RESET);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) burst(i[2:1], i[0], i[1], i[0] ^ i[1], 2'($urandom));
    $display("test bursts done");
    @(posedge clk_sys);
    dllLocked <= 1'h0;
    repeat (8) @(posedge clk_sys);
    eS = 0;
    ctrl_u.cmd(1'h1, 1'h0, 1'h1, 2'h0);
    repeat (200) @(posedge clk_sys);
    chk(eS, 0, "strobe while unlocked");
    rd(`SDRB_OFS_STAT, 32'h400 | bo);
    rd(`SDRB_OFS_STAT, 32'h0 | bo);
    @(posedge clk_sys);
    dllLocked <= 1'h1;
    $display("test unlocked done");
    complete_run();
  end
endmodule
